/* File: logic/rsl_relay_core.sv */
// Purpose: Relay core between RF modem byte streams and the single-wire link framer.
// Assumes: RF side on clk_sys; link framer on the downlink clock, crossed by toggle handshakes.
// Notes: Late flags are sticky until reset; latency counters restart at the start of each new interval, a queued receive interval at the close of the one before.
`timescale 1ns/1ps
module rsl_relay_core #(
   parameter int RING_DEPTH = 64,
   parameter int MAX_PAYLOAD = 32,
   parameter int RF_FRAG = 64,
   parameter rsl_pkg::rsl_cnt_t WIN_BASE_CYC = rsl_pkg::WIN_BASE_CYC,
   parameter rsl_pkg::rsl_cnt_t CLT_BASE_CYC = rsl_pkg::CLT_BASE_CYC,
   parameter rsl_pkg::rsl_cnt_t REQ_GUARD_CYC = rsl_pkg::REQ_GUARD_CYC,
   parameter rsl_pkg::rsl_cnt_t POLL_CYC = rsl_pkg::POLL_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   input wire rsl_pkg::rsl_mode_t mode,
   input wire logic pipeline_en,
   input wire logic window_stall,
   input wire logic reader_ack_wait,
   input wire rsl_pkg::rsl_rf_byte_t rf_rx,
   output logic rf_rx_ready,
   output rsl_pkg::rsl_rf_byte_t rf_tx,
   input wire logic rf_tx_ready,
   output logic rf_ack_start,
   output logic goto_init,
   output rsl_pkg::rsl_cnt_t rx_lat_cnt,
   output rsl_pkg::rsl_cnt_t tx_lat_cnt,
   output rsl_pkg::rsl_cnt_t delay_cnt,
   output rsl_pkg::rsl_late_t late,
   output rsl_pkg::rsl_dl_out_t dl_out,
   input wire logic dl_ready,
   input wire logic dl_eof_done,
   input wire logic ul_sof,
   input wire rsl_pkg::rsl_ul_in_t ul_in,
   output logic ul_ready
);
   import rsl_pkg::*;

   localparam int PW = $clog2(RING_DEPTH);
   localparam rsl_bcnt_t MAX_PL = rsl_bcnt_t'(MAX_PAYLOAD);
   localparam rsl_bcnt_t FRAG_LAST = rsl_bcnt_t'(RF_FRAG - 1);
   localparam logic [PW:0] PTR_FULL = {1'b1, {PW{1'b0}}};
   localparam logic [PW:0] PTR_ONE = {{PW{1'b0}}, 1'b1};

   typedef logic [PW:0] ptr_t;

   typedef struct packed {
      ptr_t rx_wr;
      ptr_t fwd_rd;
      ptr_t blk_ready;
      rsl_bcnt_t rx_blk_bytes;
      rsl_bcnt_t rx_last_bytes;
      logic rx_drop;
      logic dl_req;
      rsl_dl_word_t dl_word;
      logic ack_s1;
      logic ack_s2;
      logic done_s1;
      logic done_s2;
      logic done_s3;
      logic sof_s1;
      logic sof_s2;
      logic sof_s3;
      logic ulr_s1;
      logic ulr_s2;
      logic ul_ack;
      ptr_t tx_wr;
      ptr_t tx_rd;
      logic tx_done;
      logic tx_crc_ok;
      logic tx_empty;
      rsl_bcnt_t tx_bytes;
      rsl_bcnt_t tx_frag;
      rsl_rf_byte_t rf_tx;
      logic rf_rx_ready;
      logic ack_start;
      logic goto_init;
      logic rx_run;
      logic rx_pend;
      rsl_cnt_t rx_cnt;
      logic tx_run;
      rsl_cnt_t tx_cnt;
      rsl_cnt_t delay_cnt;
      logic poll_run;
      rsl_cnt_t poll_cnt;
      rsl_late_t late;
   } sys_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic ack;
      rsl_dl_out_t dl_out;
      logic done_tgl;
      logic sof_tgl;
      logic ul_tgl;
      rsl_ul_word_t ul_hold;
      logic uack_s1;
      logic uack_s2;
      logic ul_ready;
   } link_t;

   sys_t s_ff;
   sys_t nxt_s;
   link_t l_ff;
   link_t nxt_l;
   logic lrst_s1_ff;
   logic lrst_s2_ff;

   rsl_dl_word_t rx_mem [RING_DEPTH];
   logic [8:0] tx_mem [RING_DEPTH];

   logic rx_we;
   rsl_dl_word_t rx_wword;
   logic tx_we;
   logic [8:0] tx_wword;
   rsl_dl_word_t rx_rword;
   logic [8:0] tx_rword;
   logic relay;
   logic done_ev;
   logic sof_ev;
   logic over;
   logic can_send;
   logic tx_stop;
   rsl_cnt_t lim;
   rsl_cnt_t sum;

   assign rx_rword = rx_mem[s_ff.fwd_rd[PW-1:0]];
   assign tx_rword = tx_mem[s_ff.tx_rd[PW-1:0]];

   always_comb begin
      nxt_s = s_ff;
      rx_we = 1'b0;
      rx_wword = '0;
      tx_we = 1'b0;
      tx_wword = '0;
      over = 1'b0;
      can_send = 1'b0;
      tx_stop = 1'b0;
      lim = '0;
      sum = '0;
      relay = (mode != MODE_WINDOWED);
      nxt_s.ack_start = 1'b0;
      nxt_s.goto_init = 1'b0;
      // The ack and uplink synchronisers are read at their second stage; done and sof edges come from stages two and three
      nxt_s.ack_s1 = l_ff.ack;
      nxt_s.ack_s2 = s_ff.ack_s1;
      nxt_s.done_s1 = l_ff.done_tgl;
      nxt_s.done_s2 = s_ff.done_s1;
      nxt_s.done_s3 = s_ff.done_s2;
      nxt_s.sof_s1 = l_ff.sof_tgl;
      nxt_s.sof_s2 = s_ff.sof_s1;
      nxt_s.sof_s3 = s_ff.sof_s2;
      nxt_s.ulr_s1 = l_ff.ul_tgl;
      nxt_s.ulr_s2 = s_ff.ulr_s1;
      done_ev = s_ff.done_s2 ^ s_ff.done_s3;
      sof_ev = s_ff.sof_s2 ^ s_ff.sof_s3;

      // Receive latency: a downlink EOF closes the oldest open interval
      if (s_ff.rx_run && !(window_stall && !relay) && s_ff.rx_cnt != '1) begin
         nxt_s.rx_cnt = s_ff.rx_cnt + rsl_cnt_t'(1);
      end
      if (done_ev && s_ff.rx_run) begin
         lim = WIN_BASE_CYC + rsl_cnt_t'(s_ff.rx_last_bytes) * WIN_BYTE_CYC;
         if (!relay && s_ff.rx_cnt > lim) begin
            nxt_s.late.rx = 1'b1;
         end
         if (s_ff.rx_pend) begin
            nxt_s.rx_cnt = '0;
            nxt_s.rx_pend = 1'b0;
         end else begin
            nxt_s.rx_run = 1'b0;
         end
      end

      // RF reception into the ring; in relay modes oversize cuts the frame short
      if (rf_rx.valid && s_ff.rf_rx_ready) begin
         if (!s_ff.rx_drop) begin
            over = relay && (s_ff.rx_blk_bytes == MAX_PL);
            rx_we = 1'b1;
            rx_wword.data = rf_rx.data;
            rx_wword.last = rf_rx.last || over;
            rx_wword.bad = over;
            nxt_s.rx_wr = s_ff.rx_wr + PTR_ONE;
            nxt_s.rx_drop = over && !rf_rx.last;
            if (!over) begin
               nxt_s.rx_blk_bytes = s_ff.rx_blk_bytes + rsl_bcnt_t'(1);
            end
         end
         if (rf_rx.last) begin
            nxt_s.rx_drop = 1'b0;
            nxt_s.rx_blk_bytes = '0;
            nxt_s.rx_last_bytes = s_ff.rx_drop ? s_ff.rx_blk_bytes
                                               : s_ff.rx_blk_bytes + rsl_bcnt_t'(1);
            if (nxt_s.rx_run) begin
               nxt_s.rx_pend = 1'b1;
            end else begin
               nxt_s.rx_run = 1'b1;
               nxt_s.rx_cnt = '0;
            end
         end
      end
      if (rx_we && rx_wword.last) begin
         nxt_s.blk_ready = nxt_s.blk_ready + PTR_ONE;
      end

      // Forward one byte per completed handshake toward the link
      if (s_ff.dl_req == s_ff.ack_s2 && s_ff.fwd_rd != s_ff.rx_wr
          && (pipeline_en || s_ff.blk_ready != '0)) begin
         nxt_s.dl_word = rx_rword;
         nxt_s.dl_req = ~s_ff.dl_req;
         nxt_s.fwd_rd = s_ff.fwd_rd + PTR_ONE;
         if (rx_rword.last) begin
            nxt_s.blk_ready = nxt_s.blk_ready - PTR_ONE;
            // Start the ack while the byte is still in the crossing
            nxt_s.ack_start = !relay;
         end
      end
      nxt_s.rf_rx_ready = (nxt_s.rx_wr ^ nxt_s.fwd_rd) != PTR_FULL;

      // Uplink bytes from the link; ack is withheld while the ring is full
      if (sof_ev) begin
         nxt_s.tx_run = 1'b1;
         nxt_s.tx_cnt = '0;
         nxt_s.tx_bytes = '0;
         if (mode == MODE_RELAY_F) begin
            nxt_s.poll_run = 1'b0;
         end
      end
      if (s_ff.ulr_s2 != s_ff.ul_ack && (s_ff.tx_wr ^ s_ff.tx_rd) != PTR_FULL) begin
         nxt_s.ul_ack = ~s_ff.ul_ack;
         if (!l_ff.ul_hold.empty) begin
            tx_we = 1'b1;
            tx_wword = {l_ff.ul_hold.data, l_ff.ul_hold.last};
            nxt_s.tx_wr = s_ff.tx_wr + PTR_ONE;
            nxt_s.tx_bytes = nxt_s.tx_bytes + rsl_bcnt_t'(1);
         end
         if (l_ff.ul_hold.last) begin
            nxt_s.tx_done = !l_ff.ul_hold.empty;
            nxt_s.tx_crc_ok = l_ff.ul_hold.crc_ok;
            nxt_s.tx_empty = l_ff.ul_hold.empty;
            nxt_s.goto_init = l_ff.ul_hold.goto_init;
            // Nothing to modulate: the receiver is free again now
            tx_stop = l_ff.ul_hold.empty && s_ff.tx_run;
         end
      end

      // RF transmit
      if (s_ff.rf_tx.valid && rf_tx_ready) begin
         nxt_s.rf_tx.valid = 1'b0;
      end
      if (s_ff.tx_done && !s_ff.tx_crc_ok && !pipeline_en) begin
         // Bad frame without pipelining is discarded unsent
         nxt_s.tx_rd = s_ff.tx_wr;
         nxt_s.tx_done = 1'b0;
      end else begin
         can_send = s_ff.tx_rd != s_ff.tx_wr && (pipeline_en || s_ff.tx_done);
      end
      if (can_send && (!s_ff.rf_tx.valid || rf_tx_ready)) begin
         nxt_s.rf_tx.valid = 1'b1;
         nxt_s.rf_tx.data = tx_rword[8:1];
         // Relay modes keep one payload as one RF block
         nxt_s.rf_tx.last = tx_rword[0] || (!relay && s_ff.tx_frag == FRAG_LAST);
         nxt_s.tx_frag = nxt_s.rf_tx.last ? '0 : s_ff.tx_frag + rsl_bcnt_t'(1);
         nxt_s.tx_rd = s_ff.tx_rd + PTR_ONE;
         if (tx_rword[0]) begin
            nxt_s.tx_done = 1'b0;
         end
         tx_stop = s_ff.tx_run;
      end

      // Transmit latency pauses on reader ack wait and, in windowed mode, on card gaps
      if (s_ff.tx_run && !reader_ack_wait && s_ff.tx_cnt != '1
          && !(!relay && s_ff.tx_rd == s_ff.tx_wr && !s_ff.tx_done)) begin
         nxt_s.tx_cnt = s_ff.tx_cnt + rsl_cnt_t'(1);
      end
      if (tx_stop) begin
         nxt_s.tx_run = 1'b0;
         // Take the counts as they stand once this cycle's step is in, so the
         // captured total matches the held interval counters exactly
         sum = nxt_s.rx_cnt + nxt_s.tx_cnt;
         nxt_s.delay_cnt = sum;
         if (!relay) begin
            lim = WIN_BASE_CYC + rsl_cnt_t'(nxt_s.tx_bytes) * WIN_BYTE_CYC;
            if (s_ff.tx_cnt > lim) begin
               nxt_s.late.tx = 1'b1;
            end
         end else if (mode == MODE_RELAY_A) begin
            if (s_ff.rx_last_bytes == REQ_BYTES && nxt_s.tx_empty) begin
               lim = REQ_GUARD_CYC;
            end else begin
               lim = CLT_BASE_CYC + rsl_cnt_t'(s_ff.rx_last_bytes) * CLT_BYTE_CYC
                     + rsl_cnt_t'(nxt_s.tx_bytes) * CLT_BYTE_CYC;
            end
            if (sum > lim) begin
               nxt_s.late.delay = 1'b1;
            end
         end
      end

      // Polling answer watchdog; only the card's own time is counted
      if (s_ff.poll_run) begin
         nxt_s.poll_cnt = s_ff.poll_cnt + rsl_cnt_t'(1);
         if (s_ff.poll_cnt == POLL_CYC) begin
            nxt_s.late.card = 1'b1;
            nxt_s.poll_run = 1'b0;
         end
      end
      if (done_ev && mode == MODE_RELAY_F) begin
         nxt_s.poll_run = 1'b1;
         nxt_s.poll_cnt = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rx_we) begin
         rx_mem[s_ff.rx_wr[PW-1:0]] <= rx_wword;
      end
      if (tx_we) begin
         tx_mem[s_ff.tx_wr[PW-1:0]] <= tx_wword;
      end
   end

   // Link domain
   always_comb begin
      nxt_l = l_ff;
      nxt_l.req_s1 = s_ff.dl_req;
      nxt_l.req_s2 = l_ff.req_s1;
      nxt_l.uack_s1 = s_ff.ul_ack;
      nxt_l.uack_s2 = l_ff.uack_s1;
      if (l_ff.dl_out.valid && dl_ready) begin
         nxt_l.dl_out.valid = 1'b0;
      end
      // The word was stable two edges before the request toggle arrived
      if (!nxt_l.dl_out.valid && l_ff.req_s2 != l_ff.ack) begin
         nxt_l.dl_out.valid = 1'b1;
         nxt_l.dl_out.word = s_ff.dl_word;
         nxt_l.ack = ~l_ff.ack;
      end
      nxt_l.done_tgl = l_ff.done_tgl ^ dl_eof_done;
      nxt_l.sof_tgl = l_ff.sof_tgl ^ ul_sof;
      if (ul_in.valid && l_ff.ul_ready) begin
         nxt_l.ul_hold = ul_in.word;
         nxt_l.ul_tgl = ~l_ff.ul_tgl;
         nxt_l.ul_ready = 1'b0;
      end else begin
         nxt_l.ul_ready = l_ff.uack_s2 == l_ff.ul_tgl;
      end
   end

   // Reset reaches the link clock through its own synchroniser
   always_ff @(posedge clk_link) begin
      lrst_s1_ff <= rst;
      lrst_s2_ff <= lrst_s1_ff;
   end

   always_ff @(posedge clk_link) begin
      if (lrst_s2_ff) begin
         l_ff <= '0;
      end else begin
         l_ff <= nxt_l;
      end
   end

   assign rf_rx_ready = s_ff.rf_rx_ready;
   assign rf_tx = s_ff.rf_tx;
   assign rf_ack_start = s_ff.ack_start;
   assign goto_init = s_ff.goto_init;
   assign rx_lat_cnt = s_ff.rx_cnt;
   assign tx_lat_cnt = s_ff.tx_cnt;
   assign delay_cnt = s_ff.delay_cnt;
   assign late = s_ff.late;
   assign dl_out = l_ff.dl_out;
   assign ul_ready = l_ff.ul_ready;
endmodule

/* File: pkg/rsl_pkg.sv */
// Purpose: Shared constants and carriers for the RF to single-wire relay timing core.
// Assumes: System clock of 40 MHz; link-side serialiser and RF modem sit outside.
// Notes: Longest times round down to whole system clock cycles.
package rsl_pkg;
   localparam int CLK_SYS_NS = 25;
   localparam int NS_PER_US = 1000;
   localparam int CNT_W = 20;
   localparam int BCNT_W = 8;
   localparam int WIN_BASE_US = 500;
   localparam int WIN_BYTE_US = 11;
   localparam int CLT_BASE_US = 210;
   localparam int CLT_BYTE_US = 15;
   localparam int REQ_GUARD_US = 190;
   localparam int POLL_ANSWER_US = 1150;
   localparam int REQ_PAYLOAD_BYTES = 1;

   typedef logic [CNT_W-1:0] rsl_cnt_t;
   typedef logic [BCNT_W-1:0] rsl_bcnt_t;

   localparam rsl_cnt_t WIN_BASE_CYC = rsl_cnt_t'(WIN_BASE_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_cnt_t WIN_BYTE_CYC = rsl_cnt_t'(WIN_BYTE_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_cnt_t CLT_BASE_CYC = rsl_cnt_t'(CLT_BASE_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_cnt_t CLT_BYTE_CYC = rsl_cnt_t'(CLT_BYTE_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_cnt_t REQ_GUARD_CYC = rsl_cnt_t'(REQ_GUARD_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_cnt_t POLL_CYC = rsl_cnt_t'(POLL_ANSWER_US * NS_PER_US / CLK_SYS_NS);
   localparam rsl_bcnt_t REQ_BYTES = rsl_bcnt_t'(REQ_PAYLOAD_BYTES);

   typedef enum logic [1:0] {
      MODE_WINDOWED = 2'b00,
      MODE_RELAY_A = 2'b01,
      MODE_RELAY_F = 2'b10
   } rsl_mode_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
   } rsl_rf_byte_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic bad;
   } rsl_dl_word_t;

   typedef struct packed {
      logic valid;
      rsl_dl_word_t word;
   } rsl_dl_out_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic crc_ok;
      logic empty;
      logic goto_init;
   } rsl_ul_word_t;

   typedef struct packed {
      logic valid;
      rsl_ul_word_t word;
   } rsl_ul_in_t;

   typedef struct packed {
      logic rx;
      logic tx;
      logic delay;
      logic card;
   } rsl_late_t;
endpackage

/* File: tb/rsl_card_model.sv */
// Purpose: Card module and link framer stand-in on the link clock.
// Assumes: The bench starts uplink frames through the send task.
// Notes: slow takes one word per 256 link cycles and spaces uplink words.
`timescale 1ns/1ps
module rsl_card_model (
   input wire logic clk_link,
   input wire logic rst,
   input wire logic slow,
   input wire rsl_pkg::rsl_dl_out_t dl_out,
   output logic dl_ready,
   output logic dl_eof_done,
   output logic ul_sof,
   output rsl_pkg::rsl_ul_in_t ul_in,
   input wire logic ul_ready
);
   import rsl_pkg::*;
   int words;
   int frames;
   int to_cnt = 0;
   logic order_err;
   logic last_bad;
   logic [7:0] fw;
   logic [7:0] pace = 8'h0;
   logic [1:0] eof_dly;
   initial begin
      dl_ready = 1'b0;
      dl_eof_done = 1'b0;
      ul_sof = 1'b0;
      ul_in = '0;
   end
   always @(posedge clk_link) begin
      pace <= pace + 8'h1;
      dl_ready <= !slow || pace == 8'hff;
      dl_eof_done <= eof_dly == 2'h1;
      if (rst) begin
         words <= 0;
         frames <= 0;
         fw <= 8'h0;
         order_err <= 1'b0;
         last_bad <= 1'b0;
         eof_dly <= 2'h0;
      end else begin
         if (eof_dly != 2'h0) eof_dly <= eof_dly - 2'h1;
         if (eof_dly == 2'h1) frames <= frames + 1;
         if (dl_out.valid && dl_ready) begin
            words <= words + 1;
            last_bad <= dl_out.word.bad;
            if (dl_out.word.data !== 8'h10 + fw) order_err <= 1'b1;
            fw <= dl_out.word.last ? 8'h0 : fw + 8'h1;
            if (dl_out.word.last) eof_dly <= 2'h2;
         end
      end
   end
   // Whole reply as one frame; next word queued at the taking edge, or 64 link cycles after it when slow
   task automatic send(input int n, input logic crc, input logic emp, input logic gi);
      int i;
      int k;
      @(posedge clk_link);
      ul_sof <= 1'b1;
      @(posedge clk_link);
      ul_sof <= 1'b0;
      for (i = 0; i < n; i++) begin
         if (slow) repeat (64) @(posedge clk_link);
         ul_in <= '{1'b1, '{8'ha0 + 8'(i), i == n - 1, crc, emp, gi && i == n - 1}};
         k = 0;
         do begin
            @(posedge clk_link);
            k++;
         end while (!ul_ready && k < 4000);
         if (k >= 4000) to_cnt++;
      end
      ul_in.valid <= 1'b0;
      ul_in.word.data <= ~ul_in.word.data;
   endtask
endmodule

/* File: tb/rsl_relay_core_asserts.sv */
// Purpose: Handshake, pulse and late-flag assertions for the relay core.
// Assumes: The bench resets between mode changes.
// Notes: The rx and delay late flags are judged against the mode held when they rise.
`timescale 1ns/1ps
module rsl_relay_core_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   input wire rsl_pkg::rsl_mode_t mode,
   input wire rsl_pkg::rsl_rf_byte_t rf_tx,
   input wire logic rf_tx_ready,
   input wire logic rf_ack_start,
   input wire logic goto_init,
   input wire rsl_pkg::rsl_cnt_t rx_lat_cnt,
   input wire rsl_pkg::rsl_late_t late,
   input wire rsl_pkg::rsl_dl_out_t dl_out,
   input wire logic dl_ready,
   input wire rsl_pkg::rsl_ul_in_t ul_in,
   input wire logic ul_ready
);
   import rsl_pkg::*;
   a_tx_hold: assert property (@(posedge clk_sys) disable iff (rst)
      rf_tx.valid && !rf_tx_ready |=> $stable(rf_tx)) else $error("rf_tx moved while stalled");
   a_ack_window: assert property (@(posedge clk_sys) disable iff (rst)
      rf_ack_start |-> mode == MODE_WINDOWED ##1 !rf_ack_start) else $error("bad ack pulse");
   a_init_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      goto_init |=> !goto_init) else $error("goto_init longer than a cycle");
   a_late_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      (late & $past(late)) == $past(late)) else $error("late flag cleared");
   a_reset_clear: assert property (@(posedge clk_sys)
      rst |=> late == '0 && rx_lat_cnt == '0 && !goto_init) else $error("reset not clearing");
   a_rx_late_mode: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(late.rx) |-> mode == MODE_WINDOWED) else $error("late.rx outside windowed mode");
   a_delay_mode: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(late.delay) |-> mode == MODE_RELAY_A) else $error("late.delay outside relay A");
   a_dl_hold: assert property (@(posedge clk_link) disable iff (rst)
      dl_out.valid && !dl_ready |=> $stable(dl_out)) else $error("dl_out moved while stalled");
   a_ul_drop: assert property (@(posedge clk_link) disable iff (rst)
      ul_in.valid && ul_ready |=> !ul_ready) else $error("ul_ready stayed high after take");
   c_ack: cover property (@(posedge clk_sys) rf_ack_start);
   c_init: cover property (@(posedge clk_sys) goto_init);
   c_rx_late: cover property (@(posedge clk_sys) $rose(late.rx));
   c_card_late: cover property (@(posedge clk_sys) $rose(late.card));
endmodule

bind rsl_relay_core rsl_relay_core_chk rsl_relay_core_chk_inst (
   .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .mode(mode), .rf_tx(rf_tx),
   .rf_tx_ready(rf_tx_ready), .rf_ack_start(rf_ack_start), .goto_init(goto_init),
   .rx_lat_cnt(rx_lat_cnt), .late(late), .dl_out(dl_out), .dl_ready(dl_ready),
   .ul_in(ul_in), .ul_ready(ul_ready)
);

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the relay core against a card module model.
// Assumes: Shortened bound parameters; link clock 160 ns at an unrelated phase.
// Notes: Reset is held 24 cycles so the link side also sees three edges.
`timescale 1ns/1ps
module tb;
   import rsl_pkg::*;
   typedef struct {
      rsl_mode_t md;
      int nrx, nul, exp_dl, exp_tx, exp_ack;
      logic pipe, crc, emp, gi, bad;
   } rsl_row_t;
   localparam rsl_cnt_t W_CYC = 20'hc8;
   localparam rsl_cnt_t C_CYC = 20'h64;
   localparam rsl_cnt_t G_CYC = 20'h12c;
   localparam rsl_cnt_t P_CYC = 20'h12c;
   logic clk_sys, clk_link, rst, pipeline_en, window_stall, reader_ack_wait, card_slow;
   logic rf_rx_ready, rf_tx_ready, rf_ack_start, goto_init, dl_ready, dl_eof_done;
   logic ul_sof, ul_ready;
   rsl_mode_t mode;
   rsl_rf_byte_t rf_rx, rf_tx;
   rsl_cnt_t rx_lat_cnt, tx_lat_cnt, delay_cnt;
   rsl_late_t late;
   rsl_dl_out_t dl_out;
   rsl_ul_in_t ul_in;
   int fails = 0, checks_done = 0, tx_seen, blocks, acks, inits;
   rsl_row_t rows [7] = '{
      '{MODE_WINDOWED, 3, 4, 3, 4, 1, 0, 1, 0, 0, 0},
      '{MODE_RELAY_A, 5, 6, 5, 6, 0, 0, 1, 0, 0, 0},
      '{MODE_RELAY_A, 5, 6, 5, 6, 0, 1, 1, 0, 0, 0},
      '{MODE_RELAY_A, 2, 3, 2, 0, 0, 0, 0, 0, 0, 0},
      '{MODE_RELAY_A, 1, 1, 1, 0, 0, 0, 1, 1, 1, 0},
      '{MODE_RELAY_F, 4, 5, 4, 5, 0, 0, 1, 0, 0, 0},
      '{MODE_RELAY_A, 40, 1, 33, 0, 0, 0, 1, 1, 0, 1}
   };
   rsl_relay_core #(.WIN_BASE_CYC(W_CYC), .CLT_BASE_CYC(C_CYC), .REQ_GUARD_CYC(G_CYC),
      .POLL_CYC(P_CYC)) rsl_relay_core_inst (
      .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .mode(mode), .pipeline_en(pipeline_en),
      .window_stall(window_stall), .reader_ack_wait(reader_ack_wait), .rf_rx(rf_rx),
      .rf_rx_ready(rf_rx_ready), .rf_tx(rf_tx), .rf_tx_ready(rf_tx_ready),
      .rf_ack_start(rf_ack_start), .goto_init(goto_init), .rx_lat_cnt(rx_lat_cnt),
      .tx_lat_cnt(tx_lat_cnt), .delay_cnt(delay_cnt), .late(late), .dl_out(dl_out),
      .dl_ready(dl_ready), .dl_eof_done(dl_eof_done), .ul_sof(ul_sof), .ul_in(ul_in),
      .ul_ready(ul_ready));
   rsl_card_model rsl_card_model_inst (.clk_link(clk_link), .rst(rst), .slow(card_slow),
      .dl_out(dl_out), .dl_ready(dl_ready), .dl_eof_done(dl_eof_done), .ul_sof(ul_sof),
      .ul_in(ul_in), .ul_ready(ul_ready));
   always #12.5 clk_sys = ~clk_sys;
   initial begin
      clk_link = 1'b0;
      #37;
      forever #80 clk_link = ~clk_link;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (24) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (30) @(posedge clk_sys);
      tx_seen = 0;
      blocks = 0;
      acks = 0;
      inits = 0;
   endtask
   task automatic send_rf(input int n);
      int i;
      int k;
      for (i = 0; i < n; i++) begin
         rf_rx <= '{1'b1, 8'h10 + 8'(i), i == n - 1};
         k = 0;
         do begin
            @(posedge clk_sys);
            k++;
         end while (!rf_rx_ready && k < 200);
      end
      rf_rx <= '0;
   endtask
   task automatic wait_frame();
      int k;
      for (k = 0; k < 20000 && rsl_card_model_inst.frames == 0; k++) @(posedge clk_sys);
      if (rsl_card_model_inst.frames == 0) begin
         check(32'h0, 32'h1);
         summarize();
      end
      repeat (20) @(posedge clk_sys);
   endtask
   task automatic run_row(input rsl_row_t r);
      int k;
      mode <= r.md;
      pipeline_en <= r.pipe;
      do_reset();
      send_rf(r.nrx);
      wait_frame();
      rsl_card_model_inst.send(r.nul, r.crc, r.emp, r.gi);
      for (k = 0; k < 3000 && tx_seen < r.exp_tx; k++) @(posedge clk_sys);
      // Quiet stretch so a frame that should stay off the field gets its chance
      repeat (200) @(posedge clk_sys);
      check(rsl_card_model_inst.words, r.exp_dl);
      check(rsl_card_model_inst.last_bad, r.bad);
      check(rsl_card_model_inst.order_err, 1'b0);
      check(tx_seen, r.exp_tx);
      check(blocks, r.exp_tx > 0);
      check(acks, r.exp_ack);
      check(inits, r.gi);
      check(late, '0);
      check(rf_rx_ready, 1'b1);
      if (r.md == MODE_RELAY_A && r.exp_tx > 0) check(delay_cnt, rx_lat_cnt + tx_lat_cnt);
   endtask
   always @(posedge clk_sys) begin
      if (rf_tx.valid && rf_tx_ready) begin
         check(rf_tx.data, 8'ha0 + 8'(tx_seen));
         tx_seen++;
         if (rf_tx.last) blocks++;
      end
      if (rf_ack_start) acks++;
      if (goto_init) inits++;
      rf_tx_ready <= ~rf_tx_ready;
   end
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      mode = MODE_WINDOWED;
      pipeline_en = 1'b0;
      window_stall = 1'b0;
      reader_ack_wait = 1'b0;
      card_slow = 1'b0;
      rf_rx = '0;
      rf_tx_ready = 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      // Framer taking one word per 256 link cycles overruns the receive bound
      mode <= MODE_WINDOWED;
      card_slow <= 1'b1;
      do_reset();
      send_rf(2);
      wait_frame();
      check(late.rx, 1'b1);
      window_stall <= 1'b1;
      do_reset();
      send_rf(2);
      wait_frame();
      check(late.rx, 1'b0);
      window_stall <= 1'b0;
      mode <= MODE_RELAY_A;
      do_reset();
      send_rf(1);
      wait_frame();
      rsl_card_model_inst.send(1, 1'b1, 1'b1, 1'b1);
      repeat (100) @(posedge clk_sys);
      check(late.delay, 1'b1);
      check(inits, 1);
      card_slow <= 1'b0;
      mode <= MODE_RELAY_F;
      do_reset();
      send_rf(3);
      wait_frame();
      repeat (400) @(posedge clk_sys);
      check(late.card, 1'b1);
      rst <= 1'b1;
      repeat (24) @(posedge clk_sys);
      check({late, goto_init, rf_rx_ready, rx_lat_cnt}, '0);
      check(dl_out, '0);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(rf_rx_ready, 1'b1);
      check(rsl_card_model_inst.to_cnt, 0);
      summarize();
   end
endmodule
